/* ttci_transport.sv */
// Purpose: dual tape transport command logic, left and right halves
// Assumes: all link and panel inputs are asynchronous to mclk
// Notes: every input passes two flip-flops before use
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "ttci_regs.svh"

// Overview of operation
// - lines parallel-wired, up to eight transports
// - respond only to own selected address line
// - controller grounds select line whole operation
// - halt command clears motion latch
// - run command sets motion latch
// - run and halt are complementary
// - run always accompanied by a direction
// - backward command clears direction latch
// - ahead command sets direction latch
// - direction commands are complementary
// - program halted line clears motion latch
// - power-up inhibit puts both motors on drag, prevents motion
// - report none, one or conflicting selection
// - protect report shows write inhibit
// - two identical independent halves
// - timing, marker, data channels are bidirectional
// - write stores channel on both tracks
// - halt or program halted stop fires 100 ms brake on the motor opposite the direction of travel
// - idle motors both get drag
// - run forward: forward run, reverse drag
// - controller samples data on timing phase b
module ttci_transport
   import ttci_pkg::*;
#(
   parameter int unsigned BRAKE_CYC = `TTCI_BRAKE_CYC
)(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // cable side
   ttci_if.transport lnk,
   // panel switches, per half
   input wire logic [1:0] remote_mode,
   input wire logic [1:0][2:0] addr_setting,
   input wire logic [1:0] write_lock,
   // head electronics, per half
   input wire logic [1:0][4:0] head_rd,
   output logic [1:0][9:0] head_wr,
   // reel motor drives, per half
   output ttci_drive_e [1:0] fwd_motor,
   output ttci_drive_e [1:0] rev_motor
);
   localparam int CW = $clog2(BRAKE_CYC + 1);
   localparam int NIN = 40;

   // ***************************************************************
   // input synchronisers
   // ***************************************************************
   logic [NIN-1:0] raw;
   logic [NIN-1:0] s1_q;
   logic [NIN-1:0] s2_q;
   logic [7:0] sel;
   logic halt_c, run_c, ahead_c, back_c, halted_c, pwr_c, wmode_c;
   ttci_chan_t chan_c;
   logic [1:0][4:0] rd_c;
   logic [1:0] remote_c;
   logic [1:0][2:0] addr_c;
   logic [1:0] wlock_c;

   assign raw = {lnk.addr_sel, lnk.halt_motion_cmd, lnk.run_motion_cmd, lnk.ahead_dir_cmd,
                 lnk.backward_dir_cmd, lnk.program_halted_line, lnk.powerup_inhibit,
                 lnk.write_mode, lnk.chan, head_rd, remote_mode, addr_setting, write_lock};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   assign {sel, halt_c, run_c, ahead_c, back_c, halted_c, pwr_c, wmode_c, chan_c, rd_c,
           remote_c, addr_c, wlock_c} = s2_q;

   // ***************************************************************
   // per-half motion logic
   // ***************************************************************
   logic [1:0] hit;

   for (genvar h = 0; h < 2; h++) begin : g_half
      logic mo_q, mo_d, dir_q, dir_d;
      logic [CW-1:0] brk_q, brk_d;
      ttci_drive_e fwd_q, fwd_d, rev_q, rev_d;
      logic [9:0] wr_q, wr_d;

      assign hit[h] = remote_c[h] & sel[addr_c[h]];

      always_comb begin
         mo_d = mo_q;
         dir_d = dir_q;
         brk_d = brk_q;
         wr_d = wr_q;
         if (brk_q != '0) begin
            brk_d = brk_q - CW'(1);
         end
         if (hit[h]) begin
            if (run_c) begin
               mo_d = 1'b1;
            end
            if (halt_c) begin
               mo_d = 1'b0;
            end
            if (ahead_c) begin
               dir_d = 1'b1;
            end
            if (back_c) begin
               dir_d = 1'b0;
            end
            if (wmode_c) begin
               wr_d = {chan_c, chan_c};
            end
         end
         if (halted_c || pwr_c) begin
            mo_d = 1'b0;
         end
         if (mo_q && !mo_d) begin
            brk_d = CW'(BRAKE_CYC);
         end
         fwd_d = ttci_drv_drag;
         rev_d = ttci_drv_drag;
         if (pwr_c) begin
            fwd_d = ttci_drv_drag;
            rev_d = ttci_drv_drag;
         end else if (mo_q) begin
            fwd_d = dir_q ? ttci_drv_run : ttci_drv_drag;
            rev_d = dir_q ? ttci_drv_drag : ttci_drv_run;
         end else if (brk_q != '0) begin
            fwd_d = dir_q ? ttci_drv_off : ttci_drv_brake;
            rev_d = dir_q ? ttci_drv_brake : ttci_drv_off;
         end
      end

      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            mo_q <= 1'b0;
            dir_q <= 1'b1;
            brk_q <= '0;
            fwd_q <= ttci_drv_drag;
            rev_q <= ttci_drv_drag;
            wr_q <= '0;
         end else begin
            mo_q <= mo_d;
            dir_q <= dir_d;
            brk_q <= brk_d;
            fwd_q <= fwd_d;
            rev_q <= rev_d;
            wr_q <= wr_d;
         end
      end

      assign fwd_motor[h] = fwd_q;
      assign rev_motor[h] = rev_q;
      assign head_wr[h] = wr_q;
   end

   // ***************************************************************
   // reports and channel drive
   // ***************************************************************
   ttci_echo_e echo_q, echo_d;
   logic prot_q, prot_d;
   ttci_chan_t cho_q, cho_d;
   logic choe_n_q, choe_n_d;

   always_comb begin
      unique case (hit)
         2'b00: echo_d = ttci_echo_none;
         2'b11: echo_d = ttci_echo_conflict;
         default: echo_d = ttci_echo_one;
      endcase
      prot_d = |(hit & wlock_c);
      choe_n_d = !((|hit) && !wmode_c);
      cho_d = hit[0] ? rd_c[0] : rd_c[1];
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         echo_q <= ttci_echo_none;
         prot_q <= 1'b0;
         cho_q <= '0;
         choe_n_q <= 1'b1;
      end else begin
         echo_q <= echo_d;
         prot_q <= prot_d;
         cho_q <= cho_d;
         choe_n_q <= choe_n_d;
      end
   end

   assign lnk.sel_echo = echo_q;
   assign lnk.protect_report = prot_q;
   assign lnk.chan_dev_o = cho_q;
   assign lnk.chan_dev_oe_n = choe_n_q;
endmodule

/* ttci_regs.svh */
// Purpose: constants shared by both ends of the tape transport command link
// Assumes: mclk at 40 MHz
// Notes: offsets are byte addresses on the controller's wishbone port
`ifndef TTCI_REGS_SVH
`define TTCI_REGS_SVH

// ***************************************************************
// timing
// ***************************************************************
`define TTCI_CLK_KHZ 40000
`define TTCI_BRAKE_MS 100
`define TTCI_BRAKE_CYC (`TTCI_BRAKE_MS * `TTCI_CLK_KHZ)

// ***************************************************************
// controller register offsets
// ***************************************************************
`define TTCI_CTRL_OFS 4'h0
`define TTCI_STAT_OFS 4'h4
`define TTCI_WDAT_OFS 4'h8

// ***************************************************************
// control register fields and reset value
// ***************************************************************
`define TTCI_CTRL_UNIT_LSB 0
`define TTCI_CTRL_SEL_BIT 3
`define TTCI_CTRL_RUN_BIT 4
`define TTCI_CTRL_AHEAD_BIT 5
`define TTCI_CTRL_HALTED_BIT 6
`define TTCI_CTRL_PWROK_BIT 7
`define TTCI_CTRL_WMODE_BIT 8
`define TTCI_CTRL_RESET 9'h000

// ***************************************************************
// status register fields
// ***************************************************************
`define TTCI_STAT_ECHO_LSB 0
`define TTCI_STAT_PROT_BIT 2
`define TTCI_STAT_RDAT_LSB 3

`endif

/* ttci_pkg.sv */
// Purpose: types shared by both ends of the tape transport command link
// Assumes: nothing
// Notes: channel vector order is {data2, data1, data0, marker, timing}
package ttci_pkg;
   typedef enum logic [1:0] {
      ttci_drv_off,
      ttci_drv_drag,
      ttci_drv_run,
      ttci_drv_brake
   } ttci_drive_e;

   typedef enum logic [1:0] {
      ttci_echo_none,
      ttci_echo_one,
      ttci_echo_conflict
   } ttci_echo_e;

   typedef logic [4:0] ttci_chan_t;
endpackage

/* ttci_if.sv */
// Purpose: command and information cable between controller and transport
// Assumes: 1 on a command line means the line is asserted
// Notes: the shared channel wires are resolved here from the two enables
`timescale 1ns/100ps
interface ttci_if;
   import ttci_pkg::*;
   // select lines, 1 = held at ground (selected)
   logic [7:0] addr_sel;
   // command lines
   logic halt_motion_cmd;
   logic run_motion_cmd;
   logic ahead_dir_cmd;
   logic backward_dir_cmd;
   logic program_halted_line;
   logic powerup_inhibit;
   logic write_mode;
   // reports
   ttci_echo_e sel_echo;
   logic protect_report;
   // bidirectional channels
   ttci_chan_t chan_dev_o;
   logic chan_dev_oe_n;
   ttci_chan_t chan_ctl_o;
   logic chan_ctl_oe_n;
   ttci_chan_t chan;
   logic timing_channel;
   logic marker_channel;
   logic [2:0] data_channels;

   assign chan = !chan_dev_oe_n ? chan_dev_o : (!chan_ctl_oe_n ? chan_ctl_o : 5'h00);
   assign timing_channel = chan[0];
   assign marker_channel = chan[1];
   assign data_channels = chan[4:2];

   modport transport (
      input addr_sel, halt_motion_cmd, run_motion_cmd, ahead_dir_cmd,
      input backward_dir_cmd, program_halted_line, powerup_inhibit, write_mode, chan,
      output sel_echo, protect_report, chan_dev_o, chan_dev_oe_n
   );
   modport controller (
      output addr_sel, halt_motion_cmd, run_motion_cmd, ahead_dir_cmd,
      output backward_dir_cmd, program_halted_line, powerup_inhibit, write_mode,
      output chan_ctl_o, chan_ctl_oe_n,
      input sel_echo, protect_report, chan
   );
endinterface

/* ttci_controller.sv */
// Purpose: tape controller end, driven from registers over classic wishbone
// Assumes: one transport addressed at a time
// Notes: read channels are latched at each falling timing edge
`timescale 1ns/100ps
`include "ttci_regs.svh"
module ttci_controller
   import ttci_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // cable side
   ttci_if.controller lnk
);
   // ***************************************************************
   // synchronise returning lines
   // ***************************************************************
   logic [7:0] s1_q, s2_q, tim_q;
   ttci_chan_t chan_c;
   logic [1:0] echo_c;
   logic prot_c;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s1_q <= '0;
         s2_q <= '0;
         tim_q <= '0;
      end else begin
         s1_q <= {lnk.sel_echo, lnk.protect_report, lnk.chan};
         s2_q <= s1_q;
         tim_q <= s2_q;
      end
   end
   assign {echo_c, prot_c, chan_c} = s2_q;

   // ***************************************************************
   // registers and bus
   // ***************************************************************
   logic [8:0] ctrl_q, ctrl_d;
   ttci_chan_t wdat_q, wdat_d, rdat_q, rdat_d;
   logic ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic [7:0] sel_q, sel_d;
   logic run_q, run_d, ahead_q, ahead_d, wm_q, wm_d;
   logic halted_q, halted_d, pwr_q, pwr_d;
   logic halt_q, halt_d, back_q, back_d, ctloe_n_q, ctloe_n_d;
   logic wr_take;

   always_comb begin
      ctrl_d = ctrl_q;
      wdat_d = wdat_q;
      rdat_d = rdat_q;
      dat_d = dat_q;
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      wr_take = ack_q && wb_cyc_i && wb_stb_i && wb_we_i;
      // data taken on timing phase b
      if (tim_q[0] && !chan_c[0]) begin
         rdat_d = chan_c;
      end
      if (wr_take && wb_adr_i == `TTCI_CTRL_OFS) begin
         if (wb_sel_i[0]) begin
            ctrl_d[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            ctrl_d[8] = wb_dat_i[8];
         end
      end
      if (wr_take && wb_adr_i == `TTCI_WDAT_OFS && wb_sel_i[0]) begin
         wdat_d = wb_dat_i[4:0];
      end
      if (ack_d) begin
         unique case (wb_adr_i)
            `TTCI_CTRL_OFS: dat_d = {23'h000000, ctrl_q};
            `TTCI_STAT_OFS: dat_d = {24'h000000, rdat_q, prot_c, echo_c};
            `TTCI_WDAT_OFS: dat_d = {27'h0000000, wdat_q};
            default: dat_d = 32'h00000000;
         endcase
      end
      // hold own select line at ground
      sel_d = ctrl_q[`TTCI_CTRL_SEL_BIT] ? 8'h01 << ctrl_q[`TTCI_CTRL_UNIT_LSB +: 3] : 8'h00;
      run_d = ctrl_q[`TTCI_CTRL_RUN_BIT];
      ahead_d = ctrl_q[`TTCI_CTRL_AHEAD_BIT];
      halted_d = ctrl_q[`TTCI_CTRL_HALTED_BIT];
      pwr_d = !ctrl_q[`TTCI_CTRL_PWROK_BIT];
      wm_d = ctrl_q[`TTCI_CTRL_WMODE_BIT];
      // complements registered, no gate on the cable
      halt_d = !ctrl_q[`TTCI_CTRL_RUN_BIT];
      back_d = !ctrl_q[`TTCI_CTRL_AHEAD_BIT];
      ctloe_n_d = !ctrl_q[`TTCI_CTRL_WMODE_BIT];
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= `TTCI_CTRL_RESET;
         wdat_q <= '0;
         rdat_q <= '0;
         ack_q <= 1'b0;
         dat_q <= '0;
         sel_q <= '0;
         run_q <= 1'b0;
         ahead_q <= 1'b1;
         halted_q <= 1'b0;
         pwr_q <= 1'b1;
         wm_q <= 1'b0;
         halt_q <= 1'b1;
         back_q <= 1'b0;
         ctloe_n_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         wdat_q <= wdat_d;
         rdat_q <= rdat_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
         sel_q <= sel_d;
         run_q <= run_d;
         ahead_q <= ahead_d;
         halted_q <= halted_d;
         pwr_q <= pwr_d;
         wm_q <= wm_d;
         halt_q <= halt_d;
         back_q <= back_d;
         ctloe_n_q <= ctloe_n_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   // one driver for the whole chain
   assign lnk.addr_sel = sel_q;
   assign lnk.run_motion_cmd = run_q;
   assign lnk.halt_motion_cmd = halt_q;
   assign lnk.ahead_dir_cmd = ahead_q;
   assign lnk.backward_dir_cmd = back_q;
   assign lnk.program_halted_line = halted_q;
   assign lnk.powerup_inhibit = pwr_q;
   assign lnk.write_mode = wm_q;
   // drive channels only in write mode
   assign lnk.chan_ctl_o = wdat_q;
   assign lnk.chan_ctl_oe_n = ctloe_n_q;
endmodule

/* ttci_link_assertions.sv */
// Purpose: cable checks between controller and transport
// Assumes: inputs come straight from the cable interface
// Notes: motor drives are judged by the bench
`timescale 1ns/100ps
module ttci_link_assertions
   import ttci_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // controller to transport
   input wire logic [7:0] addr_sel,
   input wire logic halt_motion_cmd,
   input wire logic run_motion_cmd,
   input wire logic ahead_dir_cmd,
   input wire logic backward_dir_cmd,
   input wire logic write_mode,
   input wire logic chan_ctl_oe_n,
   // transport to controller
   input wire ttci_echo_e sel_echo,
   input wire logic chan_dev_oe_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_run_halt_pair: assert property (run_motion_cmd != halt_motion_cmd)
      else $error("run and halt not complementary");
   a_dir_pair: assert property (ahead_dir_cmd != backward_dir_cmd)
      else $error("direction lines not complementary");
   a_run_has_dir: assert property (run_motion_cmd |-> (ahead_dir_cmd || backward_dir_cmd))
      else $error("run without direction");
   a_sel_one_line: assert property ($onehot0(addr_sel))
      else $error("several select lines grounded");
   a_sel_held_run: assert property (
      run_motion_cmd && $past(run_motion_cmd) |-> $stable(addr_sel))
      else $error("select changed during motion");
   a_echo_idle: assert property ((addr_sel == 8'h00) [*6] |-> sel_echo == ttci_echo_none)
      else $error("echo shown with no select");
   a_dev_quiet_wr: assert property (write_mode [*6] |-> chan_dev_oe_n)
      else $error("transport drives channels in write");
   a_ctl_quiet_rd: assert property (!write_mode [*2] |-> chan_ctl_oe_n)
      else $error("controller drives channels in read");
endmodule

/* testbench.sv */
// Purpose: end to end bench of controller and transport over the cable
// Assumes: brake shortened to 20 cycles
// Notes: left half at unit 3, right half at unit 5
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
   import ttci_pkg::*;
   localparam int unsigned BRK = 20;
   localparam logic [5:0] SEL = 6'h01, RUN = 6'h02, AHD = 6'h04;
   localparam logic [5:0] HLT = 6'h08, POK = 6'h10, WMD = 6'h20;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [1:0] remote_mode = 2'h3;
   logic [1:0][2:0] addr_setting = {3'h5, 3'h3};
   logic [1:0] write_lock = 2'h0;
   logic [1:0][4:0] head_rd = '0;
   logic [1:0][9:0] head_wr;
   ttci_drive_e [1:0] fwd_motor;
   ttci_drive_e [1:0] rev_motor;
   logic [31:0] seed = 32'h77758525;
   int errors = 0;
   int cmp_count = 0;

   always #12.5 mclk = ~mclk;

   ttci_if lnk();
   ttci_transport #(.BRAKE_CYC(BRK)) u_ttci_transport (.mclk(mclk), .resetn(resetn),
      .lnk(lnk), .remote_mode(remote_mode), .addr_setting(addr_setting),
      .write_lock(write_lock), .head_rd(head_rd), .head_wr(head_wr),
      .fwd_motor(fwd_motor), .rev_motor(rev_motor));
   ttci_controller u_ttci_controller (.mclk(mclk), .resetn(resetn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lnk(lnk));
   ttci_link_assertions u_chk (.mclk(mclk), .resetn(resetn), .addr_sel(lnk.addr_sel),
      .halt_motion_cmd(lnk.halt_motion_cmd), .run_motion_cmd(lnk.run_motion_cmd),
      .ahead_dir_cmd(lnk.ahead_dir_cmd), .backward_dir_cmd(lnk.backward_dir_cmd),
      .write_mode(lnk.write_mode), .chan_ctl_oe_n(lnk.chan_ctl_oe_n),
      .sel_echo(lnk.sel_echo), .chan_dev_oe_n(lnk.chan_dev_oe_n));

   // ***************************************************************
   // helpers
   // ***************************************************************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function logic [31:0] cw(input logic [2:0] u, input logic [5:0] f);
      return {23'h0, f, u};
   endfunction

   // only the left half answers unit 3 in the lock scenario
   function automatic logic exp_prot(input logic [1:0] lk);
      return lk[0];
   endfunction

   task test_done;
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int i;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      wdat <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (wb_ack_o === 1'b1) break;
      end
      if (i == 20) begin
         errors++;
         test_done;
      end
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // polls a bounded time, then compares both motors of one half
   task automatic mot(input int h, input ttci_drive_e f, input ttci_drive_e r);
      for (int i = 0; i < 60; i++) begin
         if (fwd_motor[h] === f && rev_motor[h] === r) break;
         @(posedge mclk);
      end
      `CHK("fwd_motor", f, fwd_motor[h])
      `CHK("rev_motor", r, rev_motor[h])
   endtask

   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      test_done;
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      logic [31:0] rq;
      logic [4:0] d;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      wb(1, 4'hc, 32'hffffffff, rq);
      wb(0, 4'h0, 0, rq);
      `CHK("ctrl", 32'h0, rq);
      wb(0, 4'hc, 0, rq);
      `CHK("unmapped", 32'h0, rq);
      wb(0, 4'h4, 0, rq);
      `CHK("stat", 3'h0, rq[2:0]);
      // motion held off until power is reported good
      wb(1, 4'h0, cw(3, SEL | RUN | AHD), rq);
      repeat (8) @(posedge mclk);
      mot(0, ttci_drv_drag, ttci_drv_drag);
      wb(1, 4'h0, cw(3, SEL | RUN | AHD | POK), rq);
      mot(0, ttci_drv_run, ttci_drv_drag);
      mot(1, ttci_drv_drag, ttci_drv_drag);
      wb(0, 4'h4, 0, rq);
      `CHK("echo", 2'h1, rq[1:0]);
      wb(1, 4'h0, cw(3, SEL | AHD | POK), rq);
      mot(0, ttci_drv_off, ttci_drv_brake);
      // brake is first seen here, it must stand exactly BRK samples
      repeat (BRK - 4) @(posedge mclk);
      `CHK("rev_motor", ttci_drv_brake, rev_motor[0]);
      repeat (3) @(posedge mclk);
      `CHK("rev_motor", ttci_drv_brake, rev_motor[0]);
      @(posedge mclk);
      `CHK("rev_motor", ttci_drv_drag, rev_motor[0]);
      mot(0, ttci_drv_drag, ttci_drv_drag);
      wb(1, 4'h0, cw(3, SEL | RUN | POK), rq);
      mot(0, ttci_drv_drag, ttci_drv_run);
      wb(1, 4'h0, cw(3, SEL | RUN | POK | HLT), rq);
      mot(0, ttci_drv_brake, ttci_drv_off);
      mot(0, ttci_drv_drag, ttci_drv_drag);
      wb(1, 4'h0, cw(3, SEL | AHD | POK), rq);
      remote_mode <= 2'h2;
      wb(1, 4'h0, cw(3, SEL | RUN | AHD | POK), rq);
      repeat (8) @(posedge mclk);
      mot(0, ttci_drv_drag, ttci_drv_drag);
      wb(1, 4'h0, cw(3, SEL | AHD | POK), rq);
      remote_mode <= 2'h3;
      wb(1, 4'h0, cw(4, SEL | RUN | AHD | POK), rq);
      repeat (8) @(posedge mclk);
      mot(0, ttci_drv_drag, ttci_drv_drag);
      mot(1, ttci_drv_drag, ttci_drv_drag);
      wb(1, 4'h0, cw(4, SEL | AHD | POK), rq);
      wb(1, 4'h0, cw(5, SEL | RUN | AHD | POK), rq);
      mot(1, ttci_drv_run, ttci_drv_drag);
      mot(0, ttci_drv_drag, ttci_drv_drag);
      wb(1, 4'h0, cw(5, SEL | AHD | POK), rq);
      // both halves answering unit 3 is a conflict
      addr_setting[1] <= 3'h3;
      wb(1, 4'h0, cw(3, SEL | AHD | POK), rq);
      repeat (8) @(posedge mclk);
      wb(0, 4'h4, 0, rq);
      `CHK("echo", 2'h2, rq[1:0]);
      addr_setting[1] <= 3'h5;
      for (int k = 0; k < 4; k++) begin
         write_lock <= 2'(rnd());
         repeat (8) @(posedge mclk);
         wb(0, 4'h4, 0, rq);
         `CHK("protect", exp_prot(write_lock), rq[2]);
      end
      wb(1, 4'h0, cw(3, SEL | AHD | POK | WMD), rq);
      for (int k = 0; k < 3; k++) begin
         d = 5'(rnd());
         wb(1, 4'h8, {27'h0, d}, rq);
         repeat (8) @(posedge mclk);
         `CHK("head_wr", {d, d}, head_wr[0]);
      end
      `CHK("head_wr_r", 10'h000, head_wr[1]);
      wb(1, 4'h0, cw(3, SEL | AHD | POK), rq);
      d = 5'(rnd());
      // other data while timing is high, so a sample on the wrong phase shows
      for (int t = 0; t < 3; t++) begin
         head_rd <= {5'(rnd()), 4'(rnd()), 1'b1};
         repeat (4) @(posedge mclk);
         head_rd[0] <= {d[4:1], 1'b0};
         repeat (4) @(posedge mclk);
      end
      wb(0, 4'h4, 0, rq);
      `CHK("rd_chan", d[4:1], rq[7:4]);
      wb(1, 4'h0, cw(3, POK), rq);
      repeat (8) @(posedge mclk);
      wb(0, 4'h4, 0, rq);
      `CHK("echo", 2'h0, rq[1:0]);
      test_done;
   end
endmodule
